// file: rtl/txp_pkg.sv
package txp_pkg;

	// ****************************************
	// data path geometry
	// ****************************************
	localparam int TXP_DATA_W = 32;
	localparam int TXP_FIFO_W = 33;
	localparam int TXP_FIFO_DEPTH = 8;
	localparam int TXP_CNT_W = 4;
	localparam int TXP_WORD_SHIFT = 2;
	localparam int TXP_UNIT_SHIFT = 5;
	localparam logic [11:0] TXP_CAP_BYTES = 12'h020;

	// ****************************************
	// register map and fields
	// ****************************************
	localparam int TXP_ADDR_W = 12;
	localparam logic [11:0] TXP_ADDR_SETUP = 12'h000;
	localparam logic [11:0] TXP_ADDR_STATUS = 12'h004;
	localparam logic [11:0] TXP_ADDR_CTRL = 12'h008;
	localparam int TXP_BURST_LSB = 20;
	localparam int TXP_FILL_LSB = 8;
	localparam int TXP_DRAIN_LSB = 0;
	localparam int TXP_CTRL_EN_BIT = 0;
	localparam logic [31:0] TXP_SETUP_MASK = 32'h0070_3F3F;
	localparam logic [31:0] TXP_SETUP_RST = 32'h0010_0101;
	localparam logic [31:0] TXP_CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] TXP_BURST_MAX = 8'h80;

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [2:0] {
		TXP_F_IDLE = 3'b001,
		TXP_F_REQ = 3'b010,
		TXP_F_BURST = 3'b100
	} txp_fetch_t;

	typedef enum logic [1:0] {
		TXP_M_IDLE = 2'b01,
		TXP_M_SEND = 2'b10
	} txp_mac_t;

	// burst code to dwords: zero is the largest burst
	function automatic logic [7:0] txp_burst_words(input logic [2:0] code);
		if (code == 3'h0) begin
			return TXP_BURST_MAX;
		end
		return 8'h01 << (code - 3'h1);
	endfunction

	// threshold field in 32-byte units to a byte count
	function automatic logic [11:0] txp_unit_bytes(input logic [5:0] units);
		return {1'b0, units, 5'h00};
	endfunction

endpackage

// file: rtl/txp_fifo_if.sv
`timescale 1ns/1ps
interface txp_fifo_if #(parameter int W = 33, parameter int CW = 4);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	logic [CW-1:0] level;

	modport store (
		input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, level
	);
	modport user (
		output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, level
	);
endinterface

// file: rtl/txp_fifo.sv
`timescale 1ns/1ps
module txp_fifo
	import txp_pkg::*;
#(
	parameter int WIDTH = TXP_FIFO_W,
	parameter int DEPTH = TXP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// storage side
	txp_fifo_if.store f
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic do_push;
	logic do_pop;

	// honest flags: full blocks the filler, empty blocks the drain
	assign f.push_ready = (count != CW'(DEPTH));
	assign f.pop_valid = (count != '0);
	assign f.pop_data = mem[rd_ptr];
	assign f.level = count;
	assign do_push = clk_en && f.push_valid && f.push_ready;
	assign do_pop = clk_en && f.pop_valid && f.pop_ready;

	// storage has no reset; only the pointers and the count need a known value
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= f.push_data;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			end
			if (do_push && !do_pop) begin
				count <= count + CW'(1);
			end else if (do_pop && !do_push) begin
				count <= count - CW'(1);
			end
		end
	end

	count_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		count <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// file: rtl/txp_gate.sv
`timescale 1ns/1ps
module txp_gate
	import txp_pkg::*;
(
	// occupancy
	input wire logic [TXP_CNT_W-1:0] level,
	input wire logic [TXP_CNT_W-1:0] pkt_cnt,
	// programmed thresholds in 32-byte units
	input wire logic [5:0] tx_fill_level,
	input wire logic [5:0] tx_drain_level,
	// gates
	output logic fill_ok,
	output logic drain_ok
);
	logic [11:0] held_bytes;
	logic [11:0] free_bytes;

	// both sides work in bytes so the unit scaling lives in one place
	assign held_bytes = {6'h00, level, 2'b00};
	assign free_bytes = TXP_CAP_BYTES - held_bytes;
	assign fill_ok = (free_bytes >= txp_unit_bytes(tx_fill_level));
	// a whole packet waiting starts the sender even below the level
	assign drain_ok = (held_bytes >= txp_unit_bytes(tx_drain_level)) || (pkt_cnt != '0);
endmodule

// file: rtl/txp_tx_pacer.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
// How it works
// - burst code sits at bits 22..20; code zero means 128 dwords
// - codes 1 to 7 give bursts of 1, 2, 4, 8, 16, 32, 64 dwords
// - fill level sits at bits 13..8, counted in 32-byte units of free space
// - fetch asks for the bus only once free space reaches the fill level
// - drain level sits at bits 5..0, counted in 32-byte units held
// - sending starts at the drain level or when a whole packet is held
module txp_tx_pacer
	import txp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// apb slave
	input wire logic [TXP_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fragment fetch from host memory
	input wire logic fetch_avail,
	output logic bus_req,
	input wire logic bus_gnt,
	input wire logic rd_valid,
	input wire logic [TXP_DATA_W-1:0] rd_data,
	input wire logic rd_last,
	output logic rd_ready,
	// mac transmit side
	output logic mac_start,
	output logic mac_valid,
	output logic [TXP_DATA_W-1:0] mac_data,
	output logic mac_last,
	input wire logic mac_ready
);

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] tx_setup_word;
	logic [31:0] ctrl;
	logic tx_enable;
	logic [2:0] tx_burst_limit;
	logic [5:0] tx_fill_level;
	logic [5:0] tx_drain_level;
	logic [31:0] status;
	logic [31:0] next_prdata;
	logic mapped;
	logic wr_access;

	// ****************************************
	// engine state
	// ****************************************
	txp_fetch_t fetch_st;
	txp_mac_t mac_st;
	logic [7:0] burst_lim;
	logic [7:0] words_done;
	logic [TXP_CNT_W-1:0] pkt_cnt;
	logic fill_ok;
	logic drain_ok;
	logic take;
	logic burst_end;
	logic give;
	logic start_fetch;
	logic start_mac;

	txp_fifo_if #(.W(TXP_FIFO_W), .CW(TXP_CNT_W)) fq ();

	// ****************************************
	// field views
	// ****************************************
	assign tx_burst_limit = tx_setup_word[TXP_BURST_LSB +: 3];
	assign tx_fill_level = tx_setup_word[TXP_FILL_LSB +: 6];
	assign tx_drain_level = tx_setup_word[TXP_DRAIN_LSB +: 6];
	assign tx_enable = ctrl[TXP_CTRL_EN_BIT];

	// status shows live engine state for software
	assign status = {18'h0_0000, drain_ok, fill_ok, pkt_cnt, fq.level,
		2'b00, (mac_st == TXP_M_SEND), (fetch_st != TXP_F_IDLE)};

	// ****************************************
	// apb slave
	// ****************************************
	// a frozen block stretches the access phase rather than losing a write
	assign pready = clk_en;
	assign mapped = (paddr == TXP_ADDR_SETUP) || (paddr == TXP_ADDR_STATUS)
		|| (paddr == TXP_ADDR_CTRL);
	assign pslverr = psel && penable && !mapped;
	assign wr_access = psel && penable && pwrite && clk_en;

	// read data is chosen in the setup cycle so it leaves a flip-flop
	always_comb begin
		if (paddr == TXP_ADDR_SETUP) begin
			next_prdata = tx_setup_word;
		end else if (paddr == TXP_ADDR_STATUS) begin
			next_prdata = status;
		end else if (paddr == TXP_ADDR_CTRL) begin
			next_prdata = ctrl;
		end else begin
			next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
		end
	end

	// unused setup bits are not stored and read back as zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_setup_word <= TXP_SETUP_RST;
		end else if (wr_access && paddr == TXP_ADDR_SETUP) begin
			tx_setup_word <= pwdata & TXP_SETUP_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl <= TXP_CTRL_RST;
		end else if (wr_access && paddr == TXP_ADDR_CTRL) begin
			ctrl <= {31'h0000_0000, pwdata[TXP_CTRL_EN_BIT]};
		end
	end

	// ****************************************
	// threshold gates
	// ****************************************
	txp_gate u_gate (
		.level(fq.level),
		.pkt_cnt(pkt_cnt),
		.tx_fill_level(tx_fill_level),
		.tx_drain_level(tx_drain_level),
		.fill_ok(fill_ok),
		.drain_ok(drain_ok)
	);

	txp_fifo #(.WIDTH(TXP_FIFO_W), .DEPTH(TXP_FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.f(fq.store)
	);

	// ****************************************
	// fetch engine
	// ****************************************
	// a zero fill level would let the engine request with no room at all
	assign start_fetch = tx_enable && fetch_avail && fill_ok;
	assign bus_req = (fetch_st != TXP_F_IDLE);
	// a full fifo stalls the host read; the burst simply waits
	assign rd_ready = (fetch_st == TXP_F_BURST) && fq.push_ready && clk_en;
	assign take = rd_valid && rd_ready;
	assign burst_end = take && (rd_last || (words_done + 8'h01 == burst_lim));
	assign fq.push_valid = (fetch_st == TXP_F_BURST) && rd_valid;
	assign fq.push_data = {rd_last, rd_data};

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fetch_st <= TXP_F_IDLE;
		end else if (clk_en) begin
			case (fetch_st)
				TXP_F_IDLE: begin
					if (start_fetch) begin
						fetch_st <= TXP_F_REQ;
					end
				end
				TXP_F_REQ: begin
					if (bus_gnt) begin
						fetch_st <= TXP_F_BURST;
					end
				end
				TXP_F_BURST: begin
					if (burst_end) begin
						fetch_st <= TXP_F_IDLE;
					end
				end
				default: begin
					fetch_st <= TXP_F_IDLE;
				end
			endcase
		end
	end

	// limit is latched per burst so a mid-burst write cannot stretch it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			burst_lim <= TXP_BURST_MAX;
		end else if (clk_en && fetch_st == TXP_F_IDLE && start_fetch) begin
			burst_lim <= txp_burst_words(tx_burst_limit);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			words_done <= 8'h00;
		end else if (clk_en) begin
			if (fetch_st != TXP_F_BURST) begin
				words_done <= 8'h00;
			end else if (take) begin
				words_done <= words_done + 8'h01;
			end
		end
	end

	// ****************************************
	// whole-packet count
	// ****************************************
	assign give = mac_valid && mac_ready;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pkt_cnt <= '0;
		end else if (clk_en) begin
			if ((take && rd_last) && !(give && mac_last)) begin
				pkt_cnt <= pkt_cnt + TXP_CNT_W'(1);
			end else if ((give && mac_last) && !(take && rd_last)) begin
				pkt_cnt <= pkt_cnt - TXP_CNT_W'(1);
			end
		end
	end

	// ****************************************
	// mac drain
	// ****************************************
	// zero drain level would start on an empty fifo and send nothing
	assign start_mac = tx_enable && (mac_st == TXP_M_IDLE) && drain_ok;
	assign mac_valid = (mac_st == TXP_M_SEND) && fq.pop_valid && clk_en;
	assign fq.pop_ready = (mac_st == TXP_M_SEND) && mac_ready && clk_en;
	assign mac_data = fq.pop_data[TXP_DATA_W-1:0];
	assign mac_last = fq.pop_data[TXP_DATA_W];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mac_st <= TXP_M_IDLE;
		end else if (clk_en) begin
			case (mac_st)
				TXP_M_IDLE: begin
					if (start_mac) begin
						mac_st <= TXP_M_SEND;
					end
				end
				TXP_M_SEND: begin
					if (give && mac_last) begin
						mac_st <= TXP_M_IDLE;
					end
				end
				default: begin
					mac_st <= TXP_M_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mac_start <= 1'b0;
		end else if (clk_en) begin
			mac_start <= start_mac;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	burst_max_code_a: assert property (
		clk_en && fetch_st == TXP_F_IDLE && start_fetch && tx_burst_limit == 3'h0
		|=> burst_lim == 8'h80) else $error("code zero did not give 128 dwords");

	burst_pow_code_a: assert property (
		clk_en && fetch_st == TXP_F_IDLE && start_fetch && tx_burst_limit != 3'h0
		|=> burst_lim == (8'h01 << ($past(tx_burst_limit) - 3'h1)))
		else $error("burst limit does not match code");

	burst_length_a: assert property (
		take |-> words_done < burst_lim) else $error("burst ran past its limit");

	fill_request_a: assert property (
		$rose(bus_req) |-> $past(fill_ok) && $past(tx_enable))
		else $error("bus requested without room");

	fill_bytes_a: assert property (
		fill_ok == ((TXP_CAP_BYTES - {6'h00, fq.level, 2'b00})
		>= {1'b0, tx_fill_level, 5'h00})) else $error("fill gate not in bytes");

	drain_start_a: assert property (
		clk_en && mac_st == TXP_M_IDLE && tx_enable
		&& ({6'h00, fq.level, 2'b00} >= {1'b0, tx_drain_level, 5'h00} || pkt_cnt != '0)
		|=> mac_start && mac_st == TXP_M_SEND)
		else $error("sender did not start at drain level");

	setup_write_a: assert property (
		wr_access && paddr == TXP_ADDR_SETUP
		|=> tx_fill_level == $past(pwdata[13:8]) && tx_drain_level == $past(pwdata[5:0]))
		else $error("setup word not stored");

	packet_bound_a: assert property (
		pkt_cnt <= fq.level) else $error("more packets than words");

	unmapped_error_a: assert property (
		psel && penable && !mapped |-> pslverr && prdata == 32'h0000_0000 || pwrite)
		else $error("unmapped access not flagged");

	fifo_full_c: cover property (!fq.push_ready && rd_valid);
	big_burst_c: cover property (take && words_done == 8'h7F);
	packet_start_c: cover property (mac_start && pkt_cnt != '0);
	limit_end_c: cover property (burst_end && !rd_last);
endmodule

// file: tb/txp_host_model.sv
`timescale 1ns/1ps
module txp_host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control from the bench
	input wire logic [7:0] pkt_len,
	input wire logic slow,
	// fetch link
	input wire logic bus_req,
	input wire logic rd_ready,
	output logic fetch_avail,
	output logic bus_gnt,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic rd_last
);
	// ****************************************
	// arbiter and memory
	// ****************************************
	logic [7:0] idx;
	logic [1:0] wait_cnt;
	logic gap;

	// grant follows a request after a short or a long wait
	always @(posedge core_clk) begin
		if (sys_rst || !bus_req) begin
			bus_gnt <= 1'b0;
			wait_cnt <= 2'h0;
		end else if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
			bus_gnt <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end

	// word pointer; a slow memory idles one cycle after each take
	always @(posedge core_clk) begin
		if (sys_rst) begin
			idx <= 8'h00;
			gap <= 1'b0;
		end else begin
			gap <= slow && rd_valid && rd_ready;
			if (rd_valid && rd_ready) begin
				idx <= idx + 8'h01;
			end
		end
	end

	// idle data is scrambled so a stale word never looks valid
	assign fetch_avail = idx < pkt_len;
	assign rd_valid = bus_req && bus_gnt && !gap && fetch_avail;
	assign rd_data = rd_valid ? 32'hA000_0000 + idx : ~(32'hA000_0000 + idx);
	assign rd_last = rd_valid ? (idx == pkt_len - 8'h01) : idx[0];
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
	import txp_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic core_clk = 0, sys_rst = 1, clk_en = 1;
	logic [11:0] paddr = 0;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] pwdata = 0, prdata, rd_data, mac_data, q;
	logic fetch_avail, bus_req, bus_gnt, rd_valid, rd_last, rd_ready, e, req_q;
	logic mac_start, mac_valid, mac_last, mac_ready = 1, mac_slow = 0, slow = 0;
	logic [7:0] pkt_len = 8'h01;
	int error_cnt = 0, n_checks = 0, fill = 1, drain = 1;
	int occ, held_last, bw, last_burst, n_bursts, n_starts, n_reqs, pop_idx;

	txp_tx_pacer u_txp_tx_pacer (.core_clk, .sys_rst, .clk_en, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .fetch_avail, .bus_req, .bus_gnt,
		.rd_valid, .rd_data, .rd_last, .rd_ready, .mac_start, .mac_valid, .mac_data,
		.mac_last, .mac_ready);
	txp_host_model u_txp_host_model (.core_clk, .sys_rst, .pkt_len, .slow, .bus_req,
		.rd_ready, .fetch_avail, .bus_gnt, .rd_valid, .rd_data, .rd_last);

	// clock and a stalling mac on demand
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) mac_ready <= mac_slow ? ~mac_ready : 1'b1;

	// ****************************************
	// monitor: occupancy mirror and port checks
	// ****************************************
	// sampled mid-cycle so every design output has settled after its edge
	always @(negedge core_clk) begin
		if (sys_rst) begin
			{occ, held_last, bw, last_burst, n_bursts, n_starts, n_reqs, pop_idx} = '0;
			req_q = 0;
		end else begin
			if (bus_req && !req_q) begin
				n_reqs++;
				`CHK("free_space", 1'b1, (32 - occ * 4) >= fill * 32)
			end
			if (!bus_req && req_q) begin
				last_burst = bw;
				bw = 0;
				n_bursts++;
			end
			if (mac_start) begin
				n_starts++;
				`CHK("drain_cond", 1'b1, occ * 4 >= drain * 32 || held_last > 0)
			end
			if (rd_valid && rd_ready) begin
				occ++;
				bw++;
				held_last += rd_last;
			end
			if (mac_valid && mac_ready) begin
				`CHK("mac_data", 32'hA000_0000 + pop_idx, mac_data)
				`CHK("mac_last", pop_idx == pkt_len - 1, mac_last)
				occ--;
				held_last -= mac_last;
				pop_idx++;
			end
			req_q = bus_req;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
		apb(0, a, 32'h0000_0000);
		`CHK(nm, ex, q)
	endtask

	// fresh reset, then program levels and optionally enable
	task automatic setup(input logic [2:0] code, input int fl, input int dr,
		input logic [7:0] len, input logic en);
		sys_rst <= 1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		fill = fl;
		drain = dr;
		pkt_len <= len;
		slow <= code[0];
		mac_slow <= code[1];
		apb(1, TXP_ADDR_SETUP, {9'h0, code, 6'h0, fl[5:0], 2'h0, dr[5:0]});
		apb(1, TXP_ADDR_CTRL, {31'h0, en});
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		rd(TXP_ADDR_SETUP, 32'h0010_0101, "setup_rst");
		rd(TXP_ADDR_CTRL, 32'h0000_0000, "ctrl_rst");
		apb(1, TXP_ADDR_SETUP, 32'hFFFF_FFFF);
		rd(TXP_ADDR_SETUP, 32'h0070_3F3F, "setup_mask");
		apb(1, 12'h00C, 32'h0000_0005);
		`CHK("wr_err", 1'b1, e)
		rd(12'h00C, 32'h0000_0000, "unmapped");
		`CHK("rd_err", 1'b1, e)
		// long bursts would overrun the fill level, so only short codes run traffic
		for (int c = 0; c < 8; c++) begin
			setup(c[2:0], 1, 1, 8'd150, c inside {[1:4]});
			rd(TXP_ADDR_SETUP, {9'h0, c[2:0], 20'h0_0101}, "burst_code");
			if (c inside {[1:4]}) begin
				for (int n = 0; n < 400 && n_bursts == 0; n++) @(posedge core_clk);
				#1 `CHK("burst_len", 1 << (c - 1), last_burst)
			end
		end
		// a short whole packet starts below the drain level
		setup(3'd3, 1, 1, 8'd3, 1);
		for (int n = 0; n < 300 && pop_idx < 3; n++) @(posedge core_clk);
		#1 `CHK("pkt_burst", 3, last_burst)
		`CHK("pkt_starts", 1, n_starts)
		// drain of 64 bytes is never met by an 8 word fifo
		setup(3'd4, 1, 2, 8'd20, 1);
		repeat (80) @(posedge core_clk);
		#1 `CHK("no_start", 0, n_starts)
		`CHK("held_words", 8, occ)
		// fill of 64 bytes is never reached
		setup(3'd4, 2, 1, 8'd20, 1);
		repeat (80) @(posedge core_clk);
		#1 `CHK("no_req", 0, n_reqs)
		// frozen clock enable holds the bus
		clk_en <= 0;
		@(posedge core_clk);
		#1 `CHK("frozen_ready", 1'b0, pready)
		clk_en <= 1;
		summarize();
	end

	// watchdog: cut a hang well past the expected run
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
endmodule
